// ---- dv/naeu_exec_tb.sv ----
// Self-checking bench for the nibble arithmetic execute unit top.
// Assumes the top takes one byte per valid edge and pulses done or illegal.
`timescale 1ns/1ps
`default_nettype none
module naeu_exec_tb;
	import naeu_pkg::*;
	logic mclk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic byte_valid_in = 1'b0;
	logic [7:0] byte_in = 8'h00;
	logic preload_in = 1'b0;
	logic [3:0] preload_acc_in = 4'h0;
	logic [3:0] preload_upr_in = 4'h0;
	logic [3:0] preload_lwr_in = 4'h0;
	logic preload_carry_in = 1'b0;
	logic mem_load_in = 1'b0;
	logic [7:0] mem_addr_in = 8'h00;
	logic [3:0] mem_wdata_in = 4'h0;
	logic [3:0] acc_out, upper_pointer_reg_out, lower_pointer_reg_out, mem_rdata_out;
	logic carry_flag_out, zero_flag_out, status_flag_out, done_out, illegal_out, pending_out;
	int n_errors = 0;
	int checks_done = 0;
	logic [31:0] seed = 32'h4992_aa2a;
	logic [15:0] q [$];
	logic [3:0] m_acc, m_upr, m_lwr, k, y;
	logic m_c, m_z, m_s;
	logic [7:0] x, pa0;
	logic [23:0] got, want;
	logic [3:0] tm [0:255];
	naeu_exec dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .byte_valid_in(byte_valid_in),
		.byte_in(byte_in), .preload_in(preload_in), .preload_acc_in(preload_acc_in),
		.preload_upr_in(preload_upr_in), .preload_lwr_in(preload_lwr_in),
		.preload_carry_in(preload_carry_in), .mem_load_in(mem_load_in),
		.mem_addr_in(mem_addr_in), .mem_wdata_in(mem_wdata_in), .acc_out(acc_out),
		.upper_pointer_reg_out(upper_pointer_reg_out),
		.lower_pointer_reg_out(lower_pointer_reg_out), .carry_flag_out(carry_flag_out),
		.zero_flag_out(zero_flag_out), .status_flag_out(status_flag_out),
		.mem_rdata_out(mem_rdata_out), .done_out(done_out), .illegal_out(illegal_out),
		.pending_out(pending_out));
	// 200 MHz core clock
	always #2.5 mclk_in = ~mclk_in;
	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		v = v ^ (v << 5);
		return v;
	endfunction
	// Five-bit sums keep the carry or borrow in bit 4
	function automatic logic [4:0] add5(input logic [3:0] a, input logic [3:0] b, input logic ci);
		return {1'b0, a} + {1'b0, b} + {4'h0, ci};
	endfunction
	function automatic logic [4:0] sub5(input logic [3:0] a, input logic [3:0] b, input logic bi);
		return {1'b0, a} - {1'b0, b} - {4'h0, bi};
	endfunction
	task automatic finish_test();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		checks_done++;
		// An expectation the bench could not predict counts as a mismatch
		if (seen !== exp || $isunknown(exp))
		begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Each driver task sets every strobe once, just after the edge
	task automatic preload(input logic [3:0] a, u, l, input logic c);
		@(posedge mclk_in);
		#1 byte_valid_in = 1'b0;
		mem_load_in = 1'b0;
		preload_in = 1'b1;
		{preload_acc_in, preload_upr_in, preload_lwr_in, preload_carry_in} = {a, u, l, c};
		{m_acc, m_upr, m_lwr, m_c} = {a, u, l, c};
	endtask
	task automatic mload(input logic [7:0] a, input logic [3:0] d);
		@(posedge mclk_in);
		#1 preload_in = 1'b0;
		byte_valid_in = 1'b0;
		mem_load_in = 1'b1;
		mem_addr_in = a;
		mem_wdata_in = d;
		tm[a] = d;
	endtask
	task automatic idle();
		@(posedge mclk_in);
		#1 byte_valid_in = 1'b0;
		preload_in = 1'b0;
		mem_load_in = 1'b0;
	endtask
	task automatic send_byte(input logic [7:0] b);
		@(posedge mclk_in);
		#1 byte_valid_in = 1'b1;
		preload_in = 1'b0;
		mem_load_in = 1'b0;
		byte_in = b;
	endtask
	task automatic peek(input logic [7:0] a);
		idle();
		mem_addr_in = a;
		@(posedge mclk_in);
		#1 check("mem_rdata", {20'h0, mem_rdata_out}, {20'h0, tm[a]});
	endtask
	task automatic wait_q();
		int i;
		for (i = 0; i < 30 && q.size() != 0; i++)
			@(posedge mclk_in);
		if (q.size() != 0)
		begin
			n_errors++;
			$display("FAIL done_out expected pulse seen none");
			finish_test();
		end
	endtask
	// Works out the expected state, notes it, then sends the bytes
	task automatic run_op(input int op, input logic gap);
		logic [7:0] b0, b1, pa;
		logic [4:0] t;
		pa = {m_upr, m_lwr};
		b0 = OP_EXT;
		b1 = 8'h00;
		case (op)
			0:
			begin
				b0 = OP_DEC_ACC;
				t = sub5(m_acc, 4'h1, 1'b0);
				m_acc = t[3:0];
			end
			1:
			begin
				b0 = OP_INC_MEM;
				t = add5(tm[pa], 4'h1, 1'b0);
				tm[pa] = t[3:0];
			end
			2:
			begin
				b0 = OP_DEC_MEM;
				t = sub5(tm[pa], 4'h1, 1'b0);
				tm[pa] = t[3:0];
			end
			3:
			begin
				b0 = OP_RSUBC;
				t = sub5(tm[pa], m_acc, ~m_c);
				m_acc = t[3:0];
				m_c = ~t[4];
			end
			4:
			begin
				b0 = OP_ADD_WITH_CARRY;
				t = add5(tm[pa], m_acc, m_c);
				m_acc = t[3:0];
				m_c = t[4];
			end
			5:
			begin
				b0 = OP_CMP_MEM;
				t = sub5(tm[pa], m_acc, 1'b0);
			end
			6:
			begin
				b0 = OP_ADD_MEM;
				t = add5(m_acc, tm[pa], 1'b0);
				m_acc = t[3:0];
			end
			7:
			begin
				b0 = OP_DEC_LWR;
				t = sub5(m_lwr, 4'h1, 1'b0);
				m_lwr = t[3:0];
			end
			8:
			begin
				b0 = {OP_CMP_IMM_HI, k};
				t = sub5(k, m_acc, 1'b0);
			end
			9:
			begin
				b1 = {SUB_ADD_ACC, k};
				t = add5(m_acc, k, 1'b0);
				m_acc = t[3:0];
			end
			10:
			begin
				b1 = {SUB_RSUB_ACC, k};
				t = sub5(k, m_acc, 1'b0);
				m_acc = t[3:0];
			end
			11:
			begin
				b1 = {SUB_ADD_MEM, k};
				t = add5(tm[pa], k, 1'b0);
				tm[pa] = t[3:0];
			end
			12:
			begin
				b1 = {SUB_ADD_LWR, k};
				t = add5(m_lwr, k, 1'b0);
				m_lwr = t[3:0];
			end
			13:
			begin
				b1 = {SUB_CMP_LWR, k};
				t = sub5(k, m_lwr, 1'b0);
			end
			14:
			begin
				b1 = {SUB_ADD_UPR, k};
				t = add5(m_upr, k, 1'b0);
				m_upr = t[3:0];
			end
			15:
			begin
				b1 = {SUB_CMP_UPR, k};
				t = sub5(k, m_upr, 1'b0);
			end
			16:
			begin
				b0 = OP_PADD;
				b1 = {k, y};
				t = add5(tm[{4'h0, y}], k, 1'b0);
				tm[{4'h0, y}] = t[3:0];
			end
			17:
			begin
				b0 = OP_PCMP;
				b1 = {k, y};
				t = sub5(k, tm[{4'h0, y}], 1'b0);
			end
			default:
			begin
				b0 = OP_CMP_DIR;
				b1 = x;
				t = sub5(tm[x], m_acc, 1'b0);
			end
		endcase
		// Zero follows the result; status is the inverted carry or borrow
		m_z = (t[3:0] == 4'h0);
		m_s = ~t[4];
		q.push_back({1'b0, m_acc, m_upr, m_lwr, m_c, m_z, m_s});
		send_byte(b0);
		if (op >= 9)
		begin
			if (gap)
			begin
				idle();
				check("pending_out", {23'h0, pending_out}, 24'h00_0001);
			end
			send_byte(b1);
		end
	endtask
	// Takes the oldest note whenever a result pulse shows
	always @(negedge mclk_in)
		if (done_out === 1'b1 || illegal_out === 1'b1)
		begin
			if (q.size() == 0)
				check("unexpected pulse", 24'h00_0001, 24'h00_0000);
			else
			begin
				got = {8'h00, illegal_out, acc_out, upper_pointer_reg_out, lower_pointer_reg_out,
					carry_flag_out, zero_flag_out, status_flag_out};
				want = {8'h00, q.pop_front()};
				check("state", got, want);
			end
		end
	task automatic reset_zero();
		logic [23:0] r;
		r = {2'h0, acc_out, upper_pointer_reg_out, lower_pointer_reg_out, carry_flag_out,
			zero_flag_out, status_flag_out, mem_rdata_out, done_out, illegal_out, pending_out};
		check("reset state", r, 24'h00_0000);
		{m_acc, m_upr, m_lwr, m_c, m_z, m_s} = 15'h0000;
	endtask
	// Main sequence: every supported form with random operands
	initial
	begin
		repeat (8) @(posedge mclk_in);
		#1 rst_n_in = 1'b1;
		reset_zero();
		for (int rep = 0; rep < 4; rep++)
			for (int op = 0; op < 19; op++)
			begin
				seed = xs(seed);
				k = (rep == 0) ? 4'h0 : (rep == 1) ? 4'hF : seed[3:0];
				y = seed[7:4];
				x = seed[15:8];
				preload(seed[19:16], seed[23:20], seed[27:24], seed[28]);
				mload({4'h0, y}, seed[31:28]);
				seed = xs(seed);
				mload(x, seed[3:0]);
				mload({m_upr, m_lwr}, seed[7:4]);
				// Pointer ops move the pair; peek the word that was loaded
				pa0 = {m_upr, m_lwr};
				run_op(op, rep[0]);
				idle();
				wait_q();
				peek(pa0);
				peek({4'h0, y});
			end
		// Back to back, one and two byte forms mixed
		// Pointer-memory op second, after the accumulator decrement, before the pointer moves onto unloaded words
		run_op(0, 1'b0);
		run_op(6, 1'b0);
		run_op(14, 1'b0);
		run_op(16, 1'b0);
		idle();
		wait_q();
		// Unsupported bytes must change nothing
		q.push_back({1'b1, m_acc, m_upr, m_lwr, m_c, m_z, m_s});
		send_byte(8'h00);
		q.push_back({1'b1, m_acc, m_upr, m_lwr, m_c, m_z, m_s});
		send_byte(OP_EXT);
		send_byte(8'hF0);
		idle();
		wait_q();
		// Reset in mid-run clears registers at once
		#1 rst_n_in = 1'b0;
		#1 reset_zero();
		repeat (2) @(posedge mclk_in);
		#1 rst_n_in = 1'b1;
		reset_zero();
		run_op(0, 1'b0);
		idle();
		wait_q();
		finish_test();
	end
endmodule
`default_nettype wire

// ---- src/naeu_adder.sv ----
// Four-bit adder with carry in, carry out and zero detect.
// Assumes subtraction is formed by the caller as a + ~b + 1.
`timescale 1ns/1ps
`default_nettype none
module naeu_adder
	import naeu_pkg::*;
(
	naeu_core_if.alu bus // Operands in, sum and flags out
);
	logic [4:0] total;

	// Carry out of bit 3 doubles as the inverted borrow for subtraction
	always_comb
	begin
		total = {1'b0, bus.a} + {1'b0, bus.b} + {4'h0, bus.cin};
		bus.sum = total[3:0];
		bus.cout = total[4];
		bus.zero = (total[3:0] == NIB_ZERO);
	end
endmodule
`default_nettype wire

// ---- src/naeu_core_if.sv ----
// Carrier between the execute unit, its nibble adder and its data memory.
// Assumes all three sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface naeu_core_if;
	logic [3:0] a;
	logic [3:0] b;
	logic cin;
	logic [3:0] sum;
	logic cout;
	logic zero;
	logic [7:0] addr;
	logic we;
	logic [3:0] wdata;
	logic [3:0] rdata;
	modport ctrl(output a, b, cin, addr, we, wdata, input sum, cout, zero, rdata);
	modport alu(input a, b, cin, output sum, cout, zero);
	modport mem(input addr, we, wdata, output rdata);
endinterface
`default_nettype wire

// ---- src/naeu_data_mem.sv ----
// Nibble-wide data memory, written on the clock and read combinationally.
// Assumes the controller never writes and reads different words in one cycle.
`timescale 1ns/1ps
`default_nettype none
module naeu_data_mem
	import naeu_pkg::*;
#(
	parameter int AW = ADDR_W
)
(
	input wire logic mclk_in, // Core clock
	naeu_core_if.mem bus // Address, write strobe and data
);
	logic [3:0] cells [0:(2**AW)-1];

	// Contents are not reset; software initialises data memory itself
	always_ff @(posedge mclk_in)
	begin
		if (bus.we)
			cells[bus.addr[AW-1:0]] <= bus.wdata;
	end

	// Read-modify-write happens in one cycle through this path
	always_comb
	begin
		bus.rdata = cells[bus.addr[AW-1:0]];
	end
endmodule
`default_nettype wire

// ---- src/naeu_exec.sv ----
// Top of the nibble arithmetic execute unit: decoder, register file, flags.
// Assumes one instruction byte per cycle with byte_valid_in; the second byte
// of a two-byte form follows on a later valid cycle.
`timescale 1ns/1ps
`default_nettype none
module naeu_exec
	import naeu_pkg::*;
(
	input wire logic mclk_in, // Core clock, 200 MHz
	input wire logic rst_n_in, // Asynchronous reset, active low
	input wire logic byte_valid_in, // Instruction byte present
	input wire logic [7:0] byte_in, // Instruction byte
	input wire logic preload_in, // Load registers while idle
	input wire logic [3:0] preload_acc_in, // Accumulator load value
	input wire logic [3:0] preload_upr_in, // Upper pointer load value
	input wire logic [3:0] preload_lwr_in, // Lower pointer load value
	input wire logic preload_carry_in, // Carry load value
	input wire logic mem_load_in, // Write memory while idle
	input wire logic [7:0] mem_addr_in, // Memory address while idle
	input wire logic [3:0] mem_wdata_in, // Memory write data while idle
	output logic [3:0] acc_out, // Accumulator
	output logic [3:0] upper_pointer_reg_out, // Upper pointer
	output logic [3:0] lower_pointer_reg_out, // Lower pointer
	output logic carry_flag_out, // Carry flag
	output logic zero_flag_out, // Zero flag
	output logic status_flag_out, // Status flag
	output logic [3:0] mem_rdata_out, // Memory word at mem_addr_in
	output logic done_out, // Instruction finished, pulse
	output logic illegal_out, // Unsupported byte, pulse
	output logic pending_out // Waiting for a second byte
);
	naeu_core_if bus();
	naeu_state_type state, next_state;
	logic [3:0] acc, next_acc;
	logic [3:0] upper_pointer_reg, next_upper_pointer_reg;
	logic [3:0] lower_pointer_reg, next_lower_pointer_reg;
	logic carry_flag, next_carry_flag;
	logic zero_flag, next_zero_flag;
	logic status_flag, next_status_flag;
	logic [3:0] peek, next_peek;
	logic done, next_done;
	logic illegal, next_illegal;
	logic w_acc, w_upr, w_lwr, w_mem, upd_flags, upd_cf, sf_inv, bad;
	logic [3:0] kimm;
	logic [3:0] khi;
	logic [3:0] rd;

	naeu_adder u_adder (
		.bus(bus.alu)
	);

	naeu_data_mem #(.AW(ADDR_W)) u_mem (
		.mclk_in(mclk_in),
		.bus(bus.mem)
	);

	assign kimm = byte_in[3:0];
	assign khi = byte_in[7:4];
	assign rd = bus.rdata;

	// Decode: pick adder operands, destination and flag policy per byte
	always_comb
	begin
		bus.a = acc;
		bus.b = NIB_ZERO;
		bus.cin = 1'b0;
		bus.addr = byte_valid_in ? {upper_pointer_reg, lower_pointer_reg} : mem_addr_in;
		w_acc = 1'b0;
		w_upr = 1'b0;
		w_lwr = 1'b0;
		w_mem = 1'b0;
		upd_flags = 1'b0;
		upd_cf = 1'b0;
		sf_inv = 1'b0;
		bad = 1'b0;
		next_state = state;
		if (byte_valid_in)
		begin
			next_state = ST_OP;
			unique case (state)
				ST_OP:
				begin
					if (khi == OP_CMP_IMM_HI)
					begin
						// k minus accumulator, result dropped
						bus.a = kimm;
						bus.b = ~acc;
						bus.cin = 1'b1;
						upd_flags = 1'b1;
					end
					else
					begin
						case (byte_in)
							OP_INC_MEM:
							begin
								// Memory plus one, status is inverted carry
								bus.a = rd;
								bus.cin = 1'b1;
								w_mem = 1'b1;
								upd_flags = 1'b1;
								sf_inv = 1'b1;
							end
							OP_DEC_ACC:
							begin
								// Adding F carries out exactly when no borrow
								bus.b = NIB_ONES;
								w_acc = 1'b1;
								upd_flags = 1'b1;
							end
							OP_DEC_LWR:
							begin
								bus.a = lower_pointer_reg;
								bus.b = NIB_ONES;
								w_lwr = 1'b1;
								upd_flags = 1'b1;
							end
							OP_DEC_MEM:
							begin
								bus.a = rd;
								bus.b = NIB_ONES;
								w_mem = 1'b1;
								upd_flags = 1'b1;
							end
							OP_ADD_WITH_CARRY:
							begin
								bus.b = rd;
								bus.cin = carry_flag;
								w_acc = 1'b1;
								upd_flags = 1'b1;
								upd_cf = 1'b1;
								sf_inv = 1'b1;
							end
							OP_ADD_MEM:
							begin
								bus.b = rd;
								w_acc = 1'b1;
								upd_flags = 1'b1;
								sf_inv = 1'b1;
							end
							OP_RSUBC:
							begin
								// Memory + ~acc + carry: a clear carry borrows one
								bus.a = rd;
								bus.b = ~acc;
								bus.cin = carry_flag;
								w_acc = 1'b1;
								upd_flags = 1'b1;
								upd_cf = 1'b1;
							end
							OP_CMP_MEM:
							begin
								bus.a = rd;
								bus.b = ~acc;
								bus.cin = 1'b1;
								upd_flags = 1'b1;
							end
							OP_EXT:
								next_state = ST_EXT;
							OP_PADD:
								next_state = ST_PADD;
							OP_PCMP:
								next_state = ST_PCMP;
							OP_CMP_DIR:
								next_state = ST_DIR;
							default:
								bad = 1'b1;
						endcase
					end
				end
				ST_EXT:
				begin
					case (khi)
						SUB_ADD_ACC:
						begin
							bus.b = kimm;
							w_acc = 1'b1;
							upd_flags = 1'b1;
							sf_inv = 1'b1;
						end
						SUB_RSUB_ACC:
						begin
							bus.a = kimm;
							bus.b = ~acc;
							bus.cin = 1'b1;
							w_acc = 1'b1;
							upd_flags = 1'b1;
						end
						SUB_ADD_MEM:
						begin
							bus.a = rd;
							bus.b = kimm;
							w_mem = 1'b1;
							upd_flags = 1'b1;
							sf_inv = 1'b1;
						end
						SUB_ADD_LWR:
						begin
							bus.a = lower_pointer_reg;
							bus.b = kimm;
							w_lwr = 1'b1;
							upd_flags = 1'b1;
							sf_inv = 1'b1;
						end
						SUB_ADD_UPR:
						begin
							bus.a = upper_pointer_reg;
							bus.b = kimm;
							w_upr = 1'b1;
							upd_flags = 1'b1;
							sf_inv = 1'b1;
						end
						SUB_CMP_LWR, SUB_CMP_UPR:
						begin
							bus.a = kimm;
							bus.b = (khi == SUB_CMP_LWR) ? ~lower_pointer_reg : ~upper_pointer_reg;
							bus.cin = 1'b1;
							upd_flags = 1'b1;
						end
						default:
							bad = 1'b1;
					endcase
				end
				ST_PADD:
				begin
					// Page-0 word y in the low nibble, k in the high
					bus.addr = {NIB_ZERO, kimm};
					bus.a = rd;
					bus.b = khi;
					w_mem = 1'b1;
					upd_flags = 1'b1;
					sf_inv = 1'b1;
				end
				ST_PCMP:
				begin
					bus.addr = {NIB_ZERO, kimm};
					bus.a = khi;
					bus.b = ~rd;
					bus.cin = 1'b1;
					upd_flags = 1'b1;
				end
				ST_DIR:
				begin
					bus.addr = byte_in;
					bus.a = rd;
					bus.b = ~acc;
					bus.cin = 1'b1;
					upd_flags = 1'b1;
				end
			endcase
		end
	end

	// Memory write port: results while executing, loader while idle
	assign bus.we = w_mem | (~byte_valid_in & mem_load_in);
	assign bus.wdata = byte_valid_in ? bus.sum : mem_wdata_in;

	// Next register values; preload only acts on cycles without a byte
	always_comb
	begin
		next_acc = acc;
		next_upper_pointer_reg = upper_pointer_reg;
		next_lower_pointer_reg = lower_pointer_reg;
		next_carry_flag = carry_flag;
		next_zero_flag = zero_flag;
		next_status_flag = status_flag;
		next_peek = peek;
		next_done = upd_flags;
		next_illegal = bad;
		if (byte_valid_in)
		begin
			if (w_acc)
				next_acc = bus.sum;
			if (w_upr)
				next_upper_pointer_reg = bus.sum;
			if (w_lwr)
				next_lower_pointer_reg = bus.sum;
			if (upd_flags)
			begin
				// Compares land here too, with no destination written
				next_zero_flag = bus.zero;
				next_status_flag = sf_inv ? ~bus.cout : bus.cout;
			end
			if (upd_cf)
				next_carry_flag = bus.cout;
		end
		else
		begin
			next_peek = rd;
			if (preload_in)
			begin
				next_acc = preload_acc_in;
				next_upper_pointer_reg = preload_upr_in;
				next_lower_pointer_reg = preload_lwr_in;
				next_carry_flag = preload_carry_in;
			end
		end
	end

	// State and register file
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state <= ST_OP;
			acc <= NIB_ZERO;
			upper_pointer_reg <= NIB_ZERO;
			lower_pointer_reg <= NIB_ZERO;
			carry_flag <= RST_FLAG;
			zero_flag <= RST_FLAG;
			status_flag <= RST_FLAG;
			peek <= NIB_ZERO;
			done <= 1'b0;
			illegal <= 1'b0;
		end
		else
		begin
			state <= next_state;
			acc <= next_acc;
			upper_pointer_reg <= next_upper_pointer_reg;
			lower_pointer_reg <= next_lower_pointer_reg;
			carry_flag <= next_carry_flag;
			zero_flag <= next_zero_flag;
			status_flag <= next_status_flag;
			peek <= next_peek;
			done <= next_done;
			illegal <= next_illegal;
		end
	end

	assign acc_out = acc;
	assign upper_pointer_reg_out = upper_pointer_reg;
	assign lower_pointer_reg_out = lower_pointer_reg;
	assign carry_flag_out = carry_flag;
	assign zero_flag_out = zero_flag;
	assign status_flag_out = status_flag;
	assign mem_rdata_out = peek;
	assign done_out = done;
	assign illegal_out = illegal;
	assign pending_out = (state != ST_OP);

	// Checks on the execution results: memory writes in the cycle the byte is taken, registers one cycle after
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rst_n_in);
	logic op_go;
	logic ext_go;
	assign op_go = byte_valid_in && (state == ST_OP);
	assign ext_go = byte_valid_in && (state == ST_EXT);

	inc_mem_a: assert property (op_go && byte_in == OP_INC_MEM |->
		bus.we && bus.wdata == 4'(rd + 4'h1) ##1
		carry_flag == $past(carry_flag) && status_flag == ($past(rd) != 4'hF))
		else $error("memory increment wrong");
	dec_acc_a: assert property (op_go && byte_in == OP_DEC_ACC |=>
		acc == 4'($past(acc) - 4'h1) && carry_flag == $past(carry_flag)
		&& status_flag == ($past(acc) != 4'h0) && zero_flag == ($past(acc) == 4'h1))
		else $error("accumulator decrement wrong");
	dec_lwr_a: assert property (op_go && byte_in == OP_DEC_LWR |=>
		lower_pointer_reg == 4'($past(lower_pointer_reg) - 4'h1)
		&& carry_flag == $past(carry_flag) && acc == $past(acc))
		else $error("lower pointer decrement wrong");
	add_mem_a: assert property (op_go && byte_in == OP_ADD_MEM |=>
		acc == 4'($past(acc) + $past(rd)) && carry_flag == $past(carry_flag)
		&& status_flag == (5'($past(acc)) + 5'($past(rd)) < 5'h10))
		else $error("add memory wrong");
	add_upr_a: assert property (ext_go && khi == SUB_ADD_UPR |=>
		upper_pointer_reg == 4'($past(upper_pointer_reg) + $past(kimm)))
		else $error("upper pointer add wrong");
	add_lwr_a: assert property (ext_go && khi == SUB_ADD_LWR |=>
		lower_pointer_reg == 4'($past(lower_pointer_reg) + $past(kimm))
		&& status_flag == (5'($past(lower_pointer_reg)) + 5'($past(kimm)) < 5'h10))
		else $error("lower pointer add wrong");
	add_imm_mem_a: assert property (ext_go && khi == SUB_ADD_MEM |->
		bus.we && bus.wdata == 4'(rd + kimm))
		else $error("memory immediate add wrong");
	add_page0_a: assert property (byte_valid_in && state == ST_PADD |->
		bus.we && bus.addr == {4'h0, kimm} && bus.wdata == 4'(rd + khi))
		else $error("page zero add wrong");
	rsub_borrow_a: assert property (op_go && byte_in == OP_RSUBC |=>
		acc == 4'($past(rd) - $past(acc) - 4'(!$past(carry_flag)))
		&& carry_flag == status_flag
		&& carry_flag == (5'($past(rd)) >= 5'($past(acc)) + 5'(!$past(carry_flag))))
		else $error("reverse subtract with borrow wrong");
	rsub_imm_a: assert property (ext_go && khi == SUB_RSUB_ACC |=>
		acc == 4'($past(kimm) - $past(acc)))
		else $error("reverse subtract immediate wrong");
	compare_keep_a: assert property (op_go && khi == OP_CMP_IMM_HI |=>
		acc == $past(acc) && zero_flag == ($past(kimm) == $past(acc)) && done)
		else $error("compare changed a register");
	dec_mem_a: assert property (op_go && byte_in == OP_DEC_MEM |->
		bus.we && bus.wdata == 4'(rd - 4'h1) ##1 carry_flag == $past(carry_flag))
		else $error("memory decrement wrong");
	add_with_carry_a: assert property (op_go && byte_in == OP_ADD_WITH_CARRY |=>
		{carry_flag, acc} == 5'($past(acc)) + 5'($past(rd)) + 5'($past(carry_flag)))
		else $error("add with carry wrong");

	ext_seen_c: cover property (op_go && byte_in == OP_EXT ##1 !byte_valid_in [*2] ##1 ext_go);
	page0_seen_c: cover property (byte_valid_in && state == ST_PADD);
	illegal_seen_c: cover property (illegal);
	carry_out_c: cover property (op_go && byte_in == OP_ADD_WITH_CARRY ##1 carry_flag);
endmodule
`default_nettype wire

// ---- src/naeu_pkg.sv ----
// Constants for the nibble arithmetic execute unit: opcodes, sub-opcodes,
// widths, reset values and state codes.
// Assumes a fetch stage that presents one instruction byte per valid cycle.
// How it works
// - 0A increments memory at pointer pair
// - 09 decrements accumulator, carry kept
// - 19 decrements lower pointer, carry kept
// - 17 adds pointer memory into accumulator
// - 38 Ck adds k to upper pointer
// - 38 8k adds k to lower pointer
// - 38 4k adds k to pointer memory
// - 2F ky adds k to page-0 memory
// - 14 accumulator = memory minus accumulator, borrow
// - 38 1k accumulator = k minus accumulator
// - Compares form k minus operand (memory minus accumulator for 16 and 3E), flags only
package naeu_pkg;
	localparam int NIB_W = 4;
	localparam int ADDR_W = 8;
	localparam logic [3:0] NIB_ZERO = 4'h0;
	localparam logic [3:0] NIB_ONES = 4'hF;
	localparam logic RST_FLAG = 1'b0;
	// Single-byte opcodes
	localparam logic [7:0] OP_DEC_ACC = 8'h09;
	localparam logic [7:0] OP_INC_MEM = 8'h0A;
	localparam logic [7:0] OP_DEC_MEM = 8'h0B;
	localparam logic [7:0] OP_RSUBC = 8'h14;
	localparam logic [7:0] OP_ADD_WITH_CARRY = 8'h15;
	localparam logic [7:0] OP_CMP_MEM = 8'h16;
	localparam logic [7:0] OP_ADD_MEM = 8'h17;
	localparam logic [7:0] OP_DEC_LWR = 8'h19;
	// Prefix bytes of two-byte forms
	localparam logic [7:0] OP_PCMP = 8'h2E;
	localparam logic [7:0] OP_PADD = 8'h2F;
	localparam logic [7:0] OP_EXT = 8'h38;
	localparam logic [7:0] OP_CMP_DIR = 8'h3E;
	// Upper nibble of the single-byte immediate compare
	localparam logic [3:0] OP_CMP_IMM_HI = 4'hD;
	// Sub-opcodes in the upper nibble of the byte after the extension prefix
	localparam logic [3:0] SUB_ADD_ACC = 4'h0;
	localparam logic [3:0] SUB_RSUB_ACC = 4'h1;
	localparam logic [3:0] SUB_ADD_MEM = 4'h4;
	localparam logic [3:0] SUB_ADD_LWR = 4'h8;
	localparam logic [3:0] SUB_CMP_LWR = 4'h9;
	localparam logic [3:0] SUB_ADD_UPR = 4'hC;
	localparam logic [3:0] SUB_CMP_UPR = 4'hD;
	// Decoder states, one-hot
	typedef enum logic [4:0] {
		ST_OP = 5'h01,
		ST_EXT = 5'h02,
		ST_PADD = 5'h04,
		ST_PCMP = 5'h08,
		ST_DIR = 5'h10
	} naeu_state_type;
endpackage
